// ===== src/cpu_operand_address_unit.sv
`timescale 1ns/100ps
// Operation
// - every decoded instruction word is exactly 16 bits
// - one basic instruction accepted and completed each clock
// - longword operations; memory access in byte, word or longword
// - byte and word loads are sign-extended to a longword
// - immediates sign-extend for arithmetic, zero-extend for logic
// - only bit logic ops work on memory; others go through registers
// - delayed branch runs slot first, target is pre-slot register
// - multiply latencies: 16x16 one-three, mac16 two-three, 32-bit two-four; here fixed: mul16 1, mac16 2, mul32 2, mac32 3
// - compares set or clear the flag; adds leave it; branches follow it
// - 8-bit immediate from the word; wider ones fetched pc-relative
// - direct register mode: operand is the register, no memory access
// - register indirect: address is the register, register unchanged
// - post-increment: address is register, then add 1, 2 or 4
// - pre-decrement: subtract 1, 2 or 4 first, use and keep it
// - 4-bit displacement zero-extended, scaled by size, added to register
// - indexed: named register plus register zero, neither changed
// - 8-bit displacement zero-extended, scaled, added to global base
// - global base indexed: global base plus register zero
// - pc-relative: disp doubled or quadrupled; longword masks low pc bits
module cpu_operand_address_unit
   import opaddr_pkg::*;
(
   input  logic                clk_sys_i,      // system clock
   input  logic                reset_i,        // sync reset, high
   input  logic                issue_i,        // instruction issued
   input  logic [INSTR_W-1:0]  instr_i,        // instruction word
   input  amode_t              amode_i,        // addressing mode
   input  size_t               size_i,         // access size
   input  logic                imm_arith_i,    // imm used by arithmetic
   input  logic                mem_logic_i,    // bit logic on memory
   input  logic [WORD_W-1:0]   named_general_register_i, // rn value
   input  logic [WORD_W-1:0]   register_zero_i,          // r0 value
   input  logic [WORD_W-1:0]   global_base_register_i,   // gbr value
   input  logic [WORD_W-1:0]   pc_i,           // pc value
   input  logic [WORD_W-1:0]   src_val_i,      // second compare operand
   input  logic                cmp_en_i,       // compare op
   input  cmp_t                cmp_op_i,       // compare kind
   input  logic                cond_br_i,      // conditional branch
   input  logic                cond_true_i,    // branch if flag set
   input  logic [WORD_W-1:0]   cond_target_i,  // conditional target
   input  logic                dly_br_i,       // delayed register branch
   input  logic                mem_rvalid_i,   // load data valid
   input  size_t               ld_size_i,      // load size
   input  logic [WORD_W-1:0]   mem_rdata_i,    // load data
   input  logic                mul_start_i,    // multiply start
   input  mul_kind_t           mul_kind_i,     // multiply kind
   input  logic [WORD_W-1:0]   mul_a_i,        // multiplicand
   input  logic [WORD_W-1:0]   mul_b_i,        // multiplier
   input  logic [ACC_W-1:0]    mul_acc_i,      // accumulator in
   output logic [INSTR_W-1:0]  instr_o,        // accepted word
   output logic [WORD_W-1:0]   ea_o,           // effective address
   output logic                mem_req_o,      // memory access pulse
   output size_t               mem_size_o,     // access size
   output logic                mem_logic_o,    // read-modify-write
   output logic                rn_wr_o,        // rn write-back pulse
   output logic [WORD_W-1:0]   rn_wdata_o,     // rn write-back value
   output logic [WORD_W-1:0]   operand_o,      // register/imm operand
   output logic                ld_valid_o,     // extended load valid
   output logic [WORD_W-1:0]   ld_data_o,      // extended load data
   output logic                status_word_t_o,// compare flag
   output logic                branch_o,       // branch pulse
   output logic [WORD_W-1:0]   branch_addr_o,  // branch target
   output logic                mul_ready_o,    // multiplier free
   output logic                mul_done_o,     // multiply done pulse
   output logic [ACC_W-1:0]    mul_result_o    // multiply result
);
   mul_if mul_bus ();

   logic [WORD_W-1:0]  rn;
   logic [WORD_W-1:0]  step;
   logic [WORD_W-1:0]  d4s;
   logic [WORD_W-1:0]  d8s;
   logic [WORD_W-1:0]  imm_next;
   logic [WORD_W-1:0]  ea_next;
   logic [WORD_W-1:0]  wb_next;
   logic [WORD_W-1:0]  opnd_next;
   logic [WORD_W-1:0]  ld_next;
   logic               mem_next;
   logic               wb_en_next;
   logic               cmp_next;

   logic [INSTR_W-1:0] instr_reg;
   logic [WORD_W-1:0]  ea_reg;
   logic               mem_req_reg;
   size_t              mem_size_reg;
   logic               mem_logic_reg;
   logic               rn_wr_reg;
   logic [WORD_W-1:0]  rn_wdata_reg;
   logic [WORD_W-1:0]  operand_reg;
   logic               ld_valid_reg;
   logic [WORD_W-1:0]  ld_data_reg;
   logic               flag_reg;
   br_state_t          br_state_reg;
   logic [WORD_W-1:0]  br_tgt_reg;
   logic               branch_reg;
   logic [WORD_W-1:0]  branch_addr_reg;

   assign rn = named_general_register_i;

   // size-scaled steps and displacements
   always_comb begin
      step = 32'h1 << size_i;
      d4s  = {28'h0, instr_i[DISP4_MSB:0]} << size_i;
      d8s  = {24'h0, instr_i[DISP8_MSB:0]} << size_i;
   end

   always_comb begin
      if (imm_arith_i)
         imm_next = {{24{instr_i[IMM8_MSB]}}, instr_i[IMM8_MSB:0]};
      else
         imm_next = {24'h0, instr_i[IMM8_MSB:0]};
   end

   always_comb begin
      ea_next    = rn;
      mem_next   = 1'b1;
      wb_en_next = 1'b0;
      wb_next    = rn;
      opnd_next  = rn;
      case (amode_i)
         AM_REG: mem_next = 1'b0;
         AM_IND: ea_next = rn;
         AM_POSTINC: begin
            wb_en_next = 1'b1;
            wb_next    = rn + step;
         end
         AM_PREDEC: begin
            ea_next    = rn - step;
            wb_en_next = 1'b1;
            wb_next    = rn - step;
         end
         AM_DISP4: ea_next = rn + d4s;
         AM_IDX: ea_next = rn + register_zero_i;
         AM_GBR_DISP: ea_next = global_base_register_i + d8s;
         AM_GBR_IDX:
            ea_next = global_base_register_i + register_zero_i;
         AM_PC_DISP: begin
            // also the path for word and longword immediates
            if (size_i == SZ_LONG)
               ea_next = (pc_i & PC_LONG_MASK)
                       + {22'h0, instr_i[DISP8_MSB:0], 2'h0};
            else
               ea_next = pc_i + {23'h0, instr_i[DISP8_MSB:0], 1'h0};
         end
         AM_IMM8: begin
            mem_next  = 1'b0;
            opnd_next = imm_next;
         end
         default: mem_next = 1'b0;
      endcase
   end

   always_comb begin
      case (ld_size_i)
         SZ_BYTE: ld_next = {{24{mem_rdata_i[7]}}, mem_rdata_i[7:0]};
         SZ_WORD:
            ld_next = {{16{mem_rdata_i[15]}}, mem_rdata_i[15:0]};
         default: ld_next = mem_rdata_i;
      endcase
   end

   always_comb begin
      case (cmp_op_i)
         CMP_EQ:  cmp_next = (rn == src_val_i);
         CMP_GE:  cmp_next = ($signed(rn) >= $signed(src_val_i));
         CMP_GT:  cmp_next = ($signed(rn) > $signed(src_val_i));
         CMP_HS:  cmp_next = (rn >= src_val_i);
         CMP_HI:  cmp_next = (rn > src_val_i);
         default: cmp_next = flag_reg;
      endcase
   end

   // issue stage: a new word is taken every cycle, no stall
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         instr_reg     <= 16'h0;
         ea_reg        <= 32'h0;
         mem_req_reg   <= 1'b0;
         mem_size_reg  <= SZ_BYTE;
         mem_logic_reg <= 1'b0;
         rn_wr_reg     <= 1'b0;
         rn_wdata_reg  <= 32'h0;
         operand_reg   <= 32'h0;
      end else if (issue_i) begin
         instr_reg     <= instr_i;
         ea_reg        <= ea_next;
         mem_req_reg   <= mem_next;
         mem_size_reg  <= size_i;
         // memory operands reach the alu only for bit logic
         mem_logic_reg <= mem_logic_i && mem_next;
         rn_wr_reg     <= wb_en_next;
         rn_wdata_reg  <= wb_next;
         operand_reg   <= opnd_next;
      end else begin
         mem_req_reg   <= 1'b0;
         mem_logic_reg <= 1'b0;
         rn_wr_reg     <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         ld_valid_reg <= 1'b0;
         ld_data_reg  <= 32'h0;
      end else begin
         ld_valid_reg <= mem_rvalid_i;
         if (mem_rvalid_i)
            ld_data_reg <= ld_next;
      end
   end

   // only explicit compares touch the flag
   always_ff @(posedge clk_sys_i) begin
      if (reset_i)
         flag_reg <= 1'b0;
      else if (cmp_en_i)
         flag_reg <= cmp_next;
   end

   // delayed branch waits for the slot word; a branch in the slot is dropped
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         br_state_reg    <= BR_IDLE;
         br_tgt_reg      <= 32'h0;
         branch_reg      <= 1'b0;
         branch_addr_reg <= 32'h0;
      end else begin
         branch_reg <= 1'b0;
         case (br_state_reg)
            BR_IDLE: begin
               if (issue_i && dly_br_i) begin
                  br_tgt_reg   <= rn;
                  br_state_reg <= BR_SLOT;
               end else if (issue_i && cond_br_i
                            && flag_reg == cond_true_i) begin
                  branch_reg      <= 1'b1;
                  branch_addr_reg <= cond_target_i;
               end
            end
            BR_SLOT: begin
               if (issue_i) begin
                  branch_reg      <= 1'b1;
                  branch_addr_reg <= br_tgt_reg;
                  br_state_reg    <= BR_IDLE;
               end
            end
            default: br_state_reg <= BR_IDLE;
         endcase
      end
   end

   assign mul_bus.start = mul_start_i;
   assign mul_bus.kind  = mul_kind_i;
   assign mul_bus.a     = mul_a_i;
   assign mul_bus.b     = mul_b_i;
   assign mul_bus.acc   = mul_acc_i;

   mul_unit u_mul (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .mul       (mul_bus.unit)
   );

   assign mul_ready_o     = mul_bus.ready;
   assign mul_done_o      = mul_bus.done;
   assign mul_result_o    = mul_bus.result;
   assign instr_o         = instr_reg;
   assign ea_o            = ea_reg;
   assign mem_req_o       = mem_req_reg;
   assign mem_size_o      = mem_size_reg;
   assign mem_logic_o     = mem_logic_reg;
   assign rn_wr_o         = rn_wr_reg;
   assign rn_wdata_o      = rn_wdata_reg;
   assign operand_o       = operand_reg;
   assign ld_valid_o      = ld_valid_reg;
   assign ld_data_o       = ld_data_reg;
   assign status_word_t_o = flag_reg;
   assign branch_o        = branch_reg;
   assign branch_addr_o   = branch_addr_reg;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   property p_word;
      issue_i |=> instr_o == $past(instr_i);
   endproperty
   a_word: assert property (p_word)
      else $error("instruction word not taken whole");

   property p_rate;
      (issue_i && amode_i == AM_IND) ##1 (issue_i && amode_i == AM_IND)
         |=> mem_req_o && ea_o == $past(rn);
   endproperty
   a_rate: assert property (p_rate)
      else $error("back to back issue lost an access");

   property p_ld_byte;
      (mem_rvalid_i && ld_size_i == SZ_BYTE) |=> ld_valid_o
         && ld_data_o == {{24{$past(mem_rdata_i[7])}},
                          $past(mem_rdata_i[7:0])};
   endproperty
   a_ld_byte: assert property (p_ld_byte)
      else $error("byte load not sign extended");

   property p_imm_logic;
      (issue_i && amode_i == AM_IMM8 && !imm_arith_i)
         |=> operand_o == {24'h0, $past(instr_i[7:0])} && !mem_req_o;
   endproperty
   a_imm_logic: assert property (p_imm_logic)
      else $error("logic immediate not zero extended");

   property p_memlogic;
      mem_logic_o |-> mem_req_o;
   endproperty
   a_memlogic: assert property (p_memlogic)
      else $error("memory logic without memory access");

   sequence s_dly_issue;
      issue_i && dly_br_i && br_state_reg == BR_IDLE;
   endsequence
   sequence s_slot;
      issue_i;
   endsequence
   property p_dly;
      s_dly_issue ##1 s_slot
         |=> branch_o && branch_addr_o == $past(rn, 2);
   endproperty
   a_dly: assert property (p_dly)
      else $error("delayed branch target or timing wrong");

   property p_flag_hold;
      !cmp_en_i |=> $stable(status_word_t_o);
   endproperty
   a_flag_hold: assert property (p_flag_hold)
      else $error("flag changed without a compare");

   property p_cmp_eq;
      (cmp_en_i && cmp_op_i == CMP_EQ)
         |=> status_word_t_o == ($past(rn) == $past(src_val_i));
   endproperty
   a_cmp_eq: assert property (p_cmp_eq)
      else $error("equal compare gave wrong flag");

   property p_direct;
      (issue_i && amode_i == AM_REG)
         |=> !mem_req_o && operand_o == $past(rn);
   endproperty
   a_direct: assert property (p_direct)
      else $error("direct register mode touched memory");

   property p_ind;
      (issue_i && amode_i == AM_IND) |=> ea_o == $past(rn) && !rn_wr_o;
   endproperty
   a_ind: assert property (p_ind)
      else $error("indirect address or write-back wrong");

   property p_post;
      (issue_i && amode_i == AM_POSTINC && size_i == SZ_LONG)
         |=> ea_o == $past(rn) && rn_wr_o && rn_wdata_o == $past(rn) + 32'h4;
   endproperty
   a_post: assert property (p_post)
      else $error("post-increment wrong");

   property p_pre;
      (issue_i && amode_i == AM_PREDEC && size_i == SZ_WORD)
         |=> ea_o == $past(rn) - 32'h2 && rn_wr_o && rn_wdata_o == ea_o;
   endproperty
   a_pre: assert property (p_pre)
      else $error("pre-decrement wrong");

   property p_disp4;
      (issue_i && amode_i == AM_DISP4 && size_i == SZ_LONG)
         |=> ea_o == $past(rn) + {26'h0, $past(instr_i[3:0]), 2'h0};
   endproperty
   a_disp4: assert property (p_disp4)
      else $error("4-bit displacement address wrong");

   property p_idx;
      (issue_i && amode_i == AM_IDX)
         |=> ea_o == $past(rn) + $past(register_zero_i) && !rn_wr_o;
   endproperty
   a_idx: assert property (p_idx)
      else $error("indexed address wrong");

   property p_gbr_disp;
      (issue_i && amode_i == AM_GBR_DISP && size_i == SZ_WORD)
         |=> ea_o == $past(global_base_register_i)
                   + {23'h0, $past(instr_i[7:0]), 1'h0};
   endproperty
   a_gbr_disp: assert property (p_gbr_disp)
      else $error("global base displacement wrong");

   property p_gbr_idx;
      (issue_i && amode_i == AM_GBR_IDX) |=> ea_o
         == $past(global_base_register_i) + $past(register_zero_i);
   endproperty
   a_gbr_idx: assert property (p_gbr_idx)
      else $error("global base indexed wrong");

   property p_pc_long;
      (issue_i && amode_i == AM_PC_DISP && size_i == SZ_LONG)
         |=> ea_o == ($past(pc_i) & 32'hfffffffc)
                   + {22'h0, $past(instr_i[7:0]), 2'h0};
   endproperty
   a_pc_long: assert property (p_pc_long)
      else $error("pc-relative longword address wrong");
endmodule

// ===== inc/opaddr_pkg.sv
package opaddr_pkg;
   localparam int INSTR_W = 16;
   localparam int WORD_W  = 32;
   localparam int ACC_W   = 64;

   // operand fields inside the instruction word
   localparam int DISP4_MSB = 3;
   localparam int DISP8_MSB = 7;
   localparam int IMM8_MSB  = 7;

   // longword pc-relative base drops the two low pc bits
   localparam logic [31:0] PC_LONG_MASK = 32'hfffffffc;

   // multiply latencies in cycles, the accepting edge counted as the first
   localparam logic [1:0] LAT_MUL16 = 2'h1;
   localparam logic [1:0] LAT_MAC16 = 2'h2;
   localparam logic [1:0] LAT_MUL32 = 2'h2;
   localparam logic [1:0] LAT_MAC32 = 2'h3;

   typedef enum logic [1:0] {
      SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2
   } size_t;

   typedef enum logic [3:0] {
      AM_REG      = 4'h0, AM_IND      = 4'h1, AM_POSTINC = 4'h2,
      AM_PREDEC   = 4'h3, AM_DISP4    = 4'h4, AM_IDX     = 4'h5,
      AM_GBR_DISP = 4'h6, AM_GBR_IDX  = 4'h7, AM_PC_DISP = 4'h8,
      AM_IMM8     = 4'h9
   } amode_t;

   typedef enum logic [2:0] {
      CMP_EQ = 3'h0, CMP_GE = 3'h1, CMP_GT = 3'h2,
      CMP_HS = 3'h3, CMP_HI = 3'h4
   } cmp_t;

   typedef enum logic [1:0] {
      MK_MUL16 = 2'h0, MK_MAC16 = 2'h1, MK_MUL32 = 2'h2, MK_MAC32 = 2'h3
   } mul_kind_t;

   typedef enum logic [1:0] {BR_IDLE = 2'b01, BR_SLOT = 2'b10} br_state_t;
   typedef enum logic [1:0] {MS_IDLE = 2'b01, MS_BUSY = 2'b10} mul_state_t;
endpackage

// ===== inc/mul_if.sv
`timescale 1ns/100ps
interface mul_if;
   import opaddr_pkg::*;
   logic              start;
   mul_kind_t         kind;
   logic [WORD_W-1:0] a;
   logic [WORD_W-1:0] b;
   logic [ACC_W-1:0]  acc;
   logic              ready;
   logic              done;
   logic [ACC_W-1:0]  result;
   modport unit (input start, kind, a, b, acc, output ready, done, result);
   modport core (output start, kind, a, b, acc, input ready, done, result);
endinterface

// ===== src/mul_unit.sv
`timescale 1ns/100ps
module mul_unit
   import opaddr_pkg::*;
(
   input  logic clk_sys_i, // system clock
   input  logic reset_i,   // sync reset, high
   mul_if.unit  mul        // multiply request and answer
);
   mul_state_t        state_reg;
   logic [1:0]        cnt_reg;
   logic [ACC_W-1:0]  res_reg;
   logic              done_reg;
   logic [ACC_W-1:0]  prod_next;
   logic [1:0]        lat_next;
   logic signed [31:0] p16;
   logic signed [63:0] p32;

   always_comb begin
      p16 = $signed(mul.a[15:0]) * $signed(mul.b[15:0]);
      p32 = $signed(mul.a) * $signed(mul.b);
      case (mul.kind)
         MK_MUL16: begin
            prod_next = {{32{p16[31]}}, p16};
            lat_next  = LAT_MUL16;
         end
         MK_MAC16: begin
            prod_next = mul.acc + {{32{p16[31]}}, p16};
            lat_next  = LAT_MAC16;
         end
         MK_MUL32: begin
            prod_next = p32;
            lat_next  = LAT_MUL32;
         end
         default: begin
            prod_next = mul.acc + p32;
            lat_next  = LAT_MAC32;
         end
      endcase
   end

   assign mul.ready  = (state_reg == MS_IDLE);
   assign mul.done   = done_reg;
   assign mul.result = res_reg;

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         state_reg <= MS_IDLE;
         cnt_reg   <= 2'h0;
         done_reg  <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         case (state_reg)
            // a one-cycle kind answers at the accepting edge itself
            MS_IDLE: if (mul.start) begin
               if (lat_next == 2'h1) begin
                  done_reg <= 1'b1;
               end else begin
                  state_reg <= MS_BUSY;
                  cnt_reg   <= lat_next - 2'h1;
               end
            end
            MS_BUSY: begin
               cnt_reg <= cnt_reg - 2'h1;
               if (cnt_reg == 2'h1) begin
                  state_reg <= MS_IDLE;
                  done_reg  <= 1'b1;
               end
            end
            default: state_reg <= MS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i)
         res_reg <= 64'h0;
      else if (mul.start && mul.ready)
         res_reg <= prod_next;
   end

   sequence s_quiet2;
      !mul.done [*2];
   endsequence
   property p_mul16;
      @(posedge clk_sys_i) disable iff (reset_i)
      (mul.start && mul.ready && mul.kind == MK_MUL16) |=> mul.done;
   endproperty
   a_mul16: assert property (p_mul16)
      else $error("16x16 multiply not done after one cycle");
   property p_mac32;
      @(posedge clk_sys_i) disable iff (reset_i)
      (mul.start && mul.ready && mul.kind == MK_MAC32)
         |=> s_quiet2 ##1 mul.done;
   endproperty
   a_mac32: assert property (p_mac32)
      else $error("32x32 accumulate not done after three cycles");
endmodule

// ===== verif/mem_partner.sv
`timescale 1ns/100ps
module mem_partner
   import opaddr_pkg::*;
(
   input  logic        clk_sys_i,    // system clock
   input  logic        mem_req_i,    // access from the block
   input  size_t       mem_size_i,   // access size
   input  logic [31:0] ea_i,         // access address
   output logic        mem_rvalid_o, // load return
   output size_t       ld_size_o,    // returned size
   output logic [31:0] mem_rdata_o   // returned data
);
   initial begin
      mem_rvalid_o = 1'b0;
      ld_size_o    = SZ_BYTE;
      mem_rdata_o  = 32'h0;
   end
   // data is the low address byte repeated, so the bench can predict it
   always @(negedge clk_sys_i) begin
      mem_rvalid_o <= mem_req_i;
      ld_size_o    <= mem_size_i;
      // idle bus toggles so stale data never looks valid
      mem_rdata_o  <= mem_req_i ? {4{ea_i[7:0]}} : ~mem_rdata_o;
   end
endmodule

// ===== verif/cpu_operand_address_unit_bench.sv
`timescale 1ns/100ps
module cpu_operand_address_unit_bench;
   import opaddr_pkg::*;
   logic        clk_sys_i, reset_i, issue_i, imm_arith_i, mem_logic_i;
   logic        cmp_en_i, cond_br_i, cond_true_i, dly_br_i, mem_rvalid_i;
   logic        mul_start_i, mem_req_o, mem_logic_o, rn_wr_o, ld_valid_o;
   logic        status_word_t_o, branch_o, mul_ready_o, mul_done_o;
   logic [15:0] instr_i, instr_o;
   logic [31:0] named_general_register_i, register_zero_i, pc_i;
   logic [31:0] global_base_register_i, src_val_i, cond_target_i;
   logic [31:0] mem_rdata_i, mul_a_i, mul_b_i, ea_o, rn_wdata_o;
   logic [31:0] operand_o, ld_data_o, branch_addr_o;
   logic [63:0] mul_acc_i, mul_result_o;
   amode_t      amode_i;
   size_t       size_i, ld_size_i, mem_size_o;
   cmp_t        cmp_op_i;
   mul_kind_t   mul_kind_i;
   int          err_count, tests_run;

   cpu_operand_address_unit DUT (.*);
   mem_partner partner (.clk_sys_i(clk_sys_i), .mem_req_i(mem_req_o),
      .mem_size_i(mem_size_o), .ea_i(ea_o), .mem_rvalid_o(mem_rvalid_i),
      .ld_size_o(ld_size_i), .mem_rdata_o(mem_rdata_i));

   always #5 clk_sys_i = ~clk_sys_i;

   task automatic chk(input string nm, input logic [63:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // leaves issue_i high so callers can issue back to back
   task automatic iss(input amode_t m, input size_t s, input logic [15:0] w,
                      input logic [31:0] exp);
      amode_i = m;
      size_i = s;
      instr_i = w;
      issue_i = 1'b1;
      @(negedge clk_sys_i);
      chk("instr", instr_o, w);
      chk("size", mem_size_o, s);
      chk("wr", rn_wr_o, m == AM_POSTINC || m == AM_PREDEC);
      chk("req", mem_req_o, m != AM_REG && m != AM_IMM8);
      if (m != AM_REG && m != AM_IMM8)
         chk("ea", ea_o, exp);
   endtask

   task automatic test_modes();
      named_general_register_i = 32'h1000_0100;
      register_zero_i = 32'h20;
      global_base_register_i = 32'h4000_0000;
      pc_i = 32'h8000_0007;
      iss(AM_IND, SZ_LONG, 16'h0, 32'h1000_0100);
      iss(AM_IND, SZ_LONG, 16'h0, 32'h1000_0100);
      chk("wr", rn_wr_o, 1'b0);
      iss(AM_POSTINC, SZ_LONG, 16'h0, 32'h1000_0100);
      chk("wb", rn_wdata_o, 32'h1000_0104);
      iss(AM_POSTINC, SZ_WORD, 16'h0, 32'h1000_0100);
      chk("wb", rn_wdata_o, 32'h1000_0102);
      iss(AM_PREDEC, SZ_BYTE, 16'h0, 32'h1000_00ff);
      chk("wb", rn_wdata_o, 32'h1000_00ff);
      iss(AM_PREDEC, SZ_WORD, 16'h0, 32'h1000_00fe);
      chk("wb", rn_wdata_o, 32'h1000_00fe);
      iss(AM_DISP4, SZ_LONG, 16'hfff, 32'h1000_013c);
      iss(AM_IDX, SZ_WORD, 16'h0, 32'h1000_0120);
      iss(AM_GBR_DISP, SZ_WORD, 16'h0ff, 32'h4000_01fe);
      iss(AM_GBR_IDX, SZ_BYTE, 16'h0, 32'h4000_0020);
      iss(AM_PC_DISP, SZ_LONG, 16'h081, 32'h8000_0208);
      iss(AM_PC_DISP, SZ_WORD, 16'h081, 32'h8000_0109);
      iss(AM_REG, SZ_LONG, 16'h0, 32'h0);
      chk("opnd", operand_o, 32'h1000_0100);
      imm_arith_i = 1'b1;
      iss(AM_IMM8, SZ_LONG, 16'h0580, 32'h0);
      chk("imm", operand_o, 32'hffff_ff80);
      imm_arith_i = 1'b0;
      iss(AM_IMM8, SZ_LONG, 16'h0580, 32'h0);
      chk("imm", operand_o, 32'h80);
      issue_i = 1'b0;
      $display("modes done");
   endtask

   task automatic load(input size_t s, input logic [31:0] a, exp);
      named_general_register_i = a;
      mem_logic_i = (s == SZ_WORD);
      iss(AM_IND, s, 16'h0, a);
      chk("rmw", mem_logic_o, s == SZ_WORD);
      issue_i = 1'b0;
      mem_logic_i = 1'b0;
      for (int i = 0; i < 4; i++) begin
         @(negedge clk_sys_i);
         if (ld_valid_o === 1'b1) begin
            chk("ld", ld_data_o, exp);
            $display("load done");
            return;
         end
      end
      chk("ld timeout", 1'b0, 1'b1);
      end_of_test();
   endtask

   task automatic test_cmp();
      logic [4:0] want;
      want = 5'b00110;
      named_general_register_i = 32'h5;
      src_val_i = 32'hffff_fffb;
      cmp_en_i = 1'b1;
      for (int k = 0; k < 5; k++) begin
         cmp_op_i = cmp_t'(k);
         @(negedge clk_sys_i);
         chk("flag", status_word_t_o, want[k]);
      end
      cmp_op_i = CMP_EQ;
      src_val_i = 32'h5;
      @(negedge clk_sys_i);
      cmp_en_i = 1'b0;
      iss(AM_REG, SZ_LONG, 16'h0, 32'h0);
      chk("flag", status_word_t_o, 1'b1);
      cond_br_i = 1'b1;
      cond_true_i = 1'b1;
      cond_target_i = 32'h1234_5678;
      iss(AM_REG, SZ_LONG, 16'h0, 32'h0);
      chk("br", branch_o, 1'b1);
      chk("tgt", branch_addr_o, 32'h1234_5678);
      cond_true_i = 1'b0;
      iss(AM_REG, SZ_LONG, 16'h0, 32'h0);
      chk("br", branch_o, 1'b0);
      cond_br_i = 1'b0;
      named_general_register_i = 32'ha000;
      dly_br_i = 1'b1;
      iss(AM_REG, SZ_LONG, 16'h0, 32'h0);
      chk("br", branch_o, 1'b0);
      dly_br_i = 1'b0;
      named_general_register_i = 32'hb000;
      iss(AM_REG, SZ_LONG, 16'h0, 32'h0);
      chk("br", branch_o, 1'b1);
      chk("tgt", branch_addr_o, 32'ha000);
      issue_i = 1'b0;
      $display("compare and branch done");
   endtask

   task automatic mul(input mul_kind_t k, input logic [31:0] a, b,
                      input logic [63:0] acc, exp, input int lat);
      mul_kind_i = k;
      mul_a_i = a;
      mul_b_i = b;
      mul_acc_i = acc;
      mul_start_i = 1'b1;
      for (int i = 1; i < 7; i++) begin
         @(negedge clk_sys_i);
         if (i == 1)
            mul_start_i = 1'b0;
         if (i == 1 && lat > 1)
            chk("ready", mul_ready_o, 1'b0);
         if (mul_done_o === 1'b1) begin
            chk("lat", i, lat);
            chk("prod", mul_result_o, exp);
            return;
         end
      end
      chk("mul timeout", 1'b0, 1'b1);
      end_of_test();
   endtask

   initial begin
      {clk_sys_i, issue_i, imm_arith_i, mem_logic_i, cmp_en_i} = '0;
      {cond_br_i, cond_true_i, dly_br_i, mul_start_i} = '0;
      {instr_i, named_general_register_i, register_zero_i, pc_i} = '0;
      {global_base_register_i, src_val_i, cond_target_i} = '0;
      {mul_a_i, mul_b_i, mul_acc_i, err_count, tests_run} = '0;
      amode_i = AM_REG;
      size_i = SZ_BYTE;
      cmp_op_i = CMP_EQ;
      mul_kind_i = MK_MUL16;
      reset_i = 1'b1;
      repeat (12) @(negedge clk_sys_i);
      reset_i = 1'b0;
      test_modes();
      load(SZ_BYTE, 32'h0000_0080, 32'hffff_ff80);
      load(SZ_WORD, 32'h0000_0090, 32'hffff_9090);
      test_cmp();
      mul(MK_MAC32, 32'h3, 32'h5, 64'h7, 64'h16, 3);
      mul(MK_MUL32, 32'h1_0000, 32'h1_0000, 64'h0, 64'h1_0000_0000, 2);
      mul(MK_MAC16, 32'h2, 32'h3, 64'ha, 64'h10, 2);
      mul(MK_MUL16, 32'h100, 32'h100, 64'h0, 64'h1_0000, 1);
      $display("multiply done");
      end_of_test();
   end
endmodule
